// ### rtl/dmac_pkg.sv
// constants, fields and types shared by the dma control block
// assumes a 32-bit apb register bus and a single 10 MHz clock
//
// What this block does
// - control bits 0,1,2,10,11 select 8,16,32,64,128-bit transfers, read/write.
// - control bit 3 gates transfers; they run only with non-zero length.
// - one interrupt output, high while completion flag and control bit 4 are set.
// - control bit 5 lets a read-side end-of-packet end the transaction.
// - control bit 6 lets a write-side end-of-packet end the transaction.
// - control bit 7 makes zero length end the transaction; otherwise zero length returns to idle without setting the completion flag.
// - control bit 8 holds the read address; cleared, it advances per transfer.
// - control bit 9 holds the write address; cleared, it advances per transfer.
// - two writes of 1 to control bit 12 reset everything like system reset.
// - a status register write clears the completion flag and interrupt, unless a transaction end sets it in that cycle.
// - count, read-end and write-end flags stay readable after completion.
// - control register reads back at any time without side effects.
// - status bit 0 sets on an enabled packet end or, with control bit 7 set, a finished length.
// - length drops per written value, never below zero; bit 4 flags zero.
// - status bits 2 and 3 tell a read-side or write-side packet end.
// - status bit 1 reads 1 while a transaction is in progress.

package dmac_pkg;

   // ----------------------------------------
   // register indices and byte addresses
   // ----------------------------------------
   localparam int IDX_STATUS = 0;
   localparam int IDX_RADDR = 1;
   localparam int IDX_WADDR = 2;
   localparam int IDX_LENGTH = 3;
   localparam int IDX_CONTROL = 6;
   localparam logic [11:0] ADDR_STATUS = 12'(IDX_STATUS * 4);
   localparam logic [11:0] ADDR_RADDR = 12'(IDX_RADDR * 4);
   localparam logic [11:0] ADDR_WADDR = 12'(IDX_WADDR * 4);
   localparam logic [11:0] ADDR_LENGTH = 12'(IDX_LENGTH * 4);
   localparam logic [11:0] ADDR_CONTROL = 12'(IDX_CONTROL * 4);

   // ----------------------------------------
   // control fields
   // ----------------------------------------
   localparam int CTL_BYTE = 0;
   localparam int CTL_HALF = 1;
   localparam int CTL_WORD = 2;
   localparam int CTL_GO = 3;
   localparam int CTL_IEN = 4;
   localparam int CTL_READ_PACKET_END_ENABLE = 5;
   localparam int CTL_WEEN = 6;
   localparam int CTL_COUNT_END_ENABLE = 7;
   localparam int CTL_RFIX = 8;
   localparam int CTL_WFIX = 9;
   localparam int CTL_DWORD = 10;
   localparam int CTL_QWORD = 11;
   localparam int CTL_SRST = 12;
   localparam logic [11:0] CTL_RESET = 12'h000;

   // ----------------------------------------
   // status fields
   // ----------------------------------------
   localparam int STS_DONE = 0;
   localparam int STS_BUSY = 1;
   localparam int STS_READ_PACKET_END_FLAG = 2;
   localparam int STS_WRITE_PACKET_END_FLAG = 3;
   localparam int STS_LEN = 4;

   typedef enum logic [2:0] {
      DMAC_IDLE = 3'b001,
      DMAC_READ = 3'b010,
      DMAC_WRITE = 3'b100
   } dmac_state_t;

   typedef struct packed {
      dmac_state_t state;
      logic [11:0] ctrl;
      logic armed;
      logic done;
      logic read_packet_end_flag;
      logic write_packet_end_flag;
      logic lenf;
      logic eop_pend;
      logic [31:0] raddr;
      logic [31:0] waddr;
      logic [31:0] len;
      logic [31:0] prdata;
      logic [127:0] data;
   } dmac_regs_t;

endpackage

// ### rtl/dmac_top.sv
// dma control registers, transfer sequencer and interrupt
// assumes slaves answer rd_ack / wr_ack in this clock domain
//
// Added by the designer: the register offsets and the APB slave port.
`timescale 1ns/1ns

module dmac_top (
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic rd_req,
   output logic [31:0] rd_addr,
   input wire logic rd_ack,
   input wire logic [127:0] rd_data,
   input wire logic rd_eop,
   output logic wr_req,
   output logic [31:0] wr_addr,
   output logic [127:0] wr_data,
   input wire logic wr_ack,
   input wire logic wr_eop,
   output logic [4:0] width_sel,
   output logic irq
);

   localparam dmac_pkg::dmac_regs_t REGS_RESET = '{state: dmac_pkg::DMAC_IDLE,
                                                  ctrl: dmac_pkg::CTL_RESET,
                                                  default: '0};

   dmac_pkg::dmac_regs_t r;
   dmac_pkg::dmac_regs_t next_r;
   logic [31:0] step;
   logic [31:0] len_dec;
   logic apb_wr;
   logic apb_setup_rd;
   logic mapped;
   logic end_now;

   // ----------------------------------------
   // transfer size and decode
   // ----------------------------------------
   // one-hot assumed; mixed selects give a mix of sizes
   always_comb begin
      step = '0;
      if (r.ctrl[dmac_pkg::CTL_BYTE]) step = step | 32'h0000_0001;
      if (r.ctrl[dmac_pkg::CTL_HALF]) step = step | 32'h0000_0002;
      if (r.ctrl[dmac_pkg::CTL_WORD]) step = step | 32'h0000_0004;
      if (r.ctrl[dmac_pkg::CTL_DWORD]) step = step | 32'h0000_0008;
      if (r.ctrl[dmac_pkg::CTL_QWORD]) step = step | 32'h0000_0010;
   end

   // saturate so the count never wraps under zero
   assign len_dec = (r.len > step) ? r.len - step : 32'h0000_0000;
   assign apb_wr = psel & penable & pwrite;
   assign apb_setup_rd = psel & ~penable & ~pwrite;
   assign mapped = (paddr == dmac_pkg::ADDR_STATUS) || (paddr == dmac_pkg::ADDR_RADDR) ||
                   (paddr == dmac_pkg::ADDR_WADDR) || (paddr == dmac_pkg::ADDR_LENGTH) ||
                   (paddr == dmac_pkg::ADDR_CONTROL);

   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb begin
      next_r = r;
      end_now = 1'b0;
      // read data latched in setup so prdata comes from a flop
      if (apb_setup_rd) begin
         next_r.prdata = '0;
         case (paddr)
            dmac_pkg::ADDR_STATUS: begin
               next_r.prdata[dmac_pkg::STS_DONE] = r.done;
               next_r.prdata[dmac_pkg::STS_BUSY] = r.state != dmac_pkg::DMAC_IDLE;
               next_r.prdata[dmac_pkg::STS_READ_PACKET_END_FLAG] = r.read_packet_end_flag;
               next_r.prdata[dmac_pkg::STS_WRITE_PACKET_END_FLAG] = r.write_packet_end_flag;
               next_r.prdata[dmac_pkg::STS_LEN] = r.lenf;
            end
            dmac_pkg::ADDR_RADDR: next_r.prdata = r.raddr;
            dmac_pkg::ADDR_WADDR: next_r.prdata = r.waddr;
            dmac_pkg::ADDR_LENGTH: next_r.prdata = r.len;
            dmac_pkg::ADDR_CONTROL: begin
               next_r.prdata[11:0] = r.ctrl;
               next_r.prdata[dmac_pkg::CTL_SRST] = r.armed;
            end
            default: next_r.prdata = '0;
         endcase
      end
      // software writes first, so a hardware set below wins over a clear
      if (apb_wr) begin
         case (paddr)
            dmac_pkg::ADDR_STATUS: begin
               next_r.done = 1'b0;
               next_r.read_packet_end_flag = 1'b0;
               next_r.write_packet_end_flag = 1'b0;
               next_r.lenf = 1'b0;
            end
            dmac_pkg::ADDR_RADDR: next_r.raddr = pwdata;
            dmac_pkg::ADDR_WADDR: next_r.waddr = pwdata;
            dmac_pkg::ADDR_LENGTH: next_r.len = pwdata;
            dmac_pkg::ADDR_CONTROL: begin
               next_r.ctrl = pwdata[11:0];
               next_r.armed = pwdata[dmac_pkg::CTL_SRST];
            end
            default: next_r.ctrl = next_r.ctrl;
         endcase
      end
      case (r.state)
         dmac_pkg::DMAC_IDLE: begin
            // a finished transaction waits for status clear before rerunning
            if (r.ctrl[dmac_pkg::CTL_GO] && r.len != 32'h0000_0000 && !r.done) begin
               next_r.state = dmac_pkg::DMAC_READ;
            end
         end
         dmac_pkg::DMAC_READ: begin
            if (rd_ack) begin
               next_r.data = rd_data;
               if (!r.ctrl[dmac_pkg::CTL_RFIX]) next_r.raddr = r.raddr + step;
               // the value read with the packet end is still written out
               if (r.ctrl[dmac_pkg::CTL_READ_PACKET_END_ENABLE] && rd_eop) next_r.eop_pend = 1'b1;
               next_r.state = dmac_pkg::DMAC_WRITE;
            end
         end
         dmac_pkg::DMAC_WRITE: begin
            if (wr_ack) begin
               if (!r.ctrl[dmac_pkg::CTL_WFIX]) next_r.waddr = r.waddr + step;
               next_r.len = len_dec;
               if (len_dec == 32'h0000_0000) next_r.lenf = 1'b1;
               if (r.ctrl[dmac_pkg::CTL_WEEN] && wr_eop) begin
                  next_r.write_packet_end_flag = 1'b1;
                  end_now = 1'b1;
               end else if (r.eop_pend) begin
                  next_r.read_packet_end_flag = 1'b1;
                  end_now = 1'b1;
               end else if (r.ctrl[dmac_pkg::CTL_COUNT_END_ENABLE] && len_dec == 32'h0000_0000) begin
                  end_now = 1'b1;
               end else if (!r.ctrl[dmac_pkg::CTL_GO] || len_dec == 32'h0000_0000) begin
                  next_r.state = dmac_pkg::DMAC_IDLE;
               end else begin
                  next_r.state = dmac_pkg::DMAC_READ;
               end
               if (end_now) begin
                  next_r.done = 1'b1;
                  next_r.eop_pend = 1'b0;
                  next_r.state = dmac_pkg::DMAC_IDLE;
               end
            end
         end
         default: next_r.state = dmac_pkg::DMAC_IDLE;
      endcase
      // second write of the reset bit wins over everything
      if (apb_wr && paddr == dmac_pkg::ADDR_CONTROL && pwdata[dmac_pkg::CTL_SRST] && r.armed) begin
         next_r = REGS_RESET;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         r <= REGS_RESET;
      end else begin
         r <= next_r;
      end
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   assign prdata = r.prdata;
   assign pready = 1'b1;
   assign pslverr = psel & penable & ~mapped;
   assign rd_req = r.state == dmac_pkg::DMAC_READ;
   assign rd_addr = r.raddr;
   assign wr_req = r.state == dmac_pkg::DMAC_WRITE;
   assign wr_addr = r.waddr;
   assign wr_data = r.data;
   assign width_sel = {r.ctrl[dmac_pkg::CTL_QWORD], r.ctrl[dmac_pkg::CTL_DWORD],
                       r.ctrl[dmac_pkg::CTL_WORD], r.ctrl[dmac_pkg::CTL_HALF],
                       r.ctrl[dmac_pkg::CTL_BYTE]};
   assign irq = r.done & r.ctrl[dmac_pkg::CTL_IEN];

   // ----------------------------------------
   // checks
   // ----------------------------------------
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rst_b);

   irq_level_a: assert property (irq == (r.done && r.ctrl[dmac_pkg::CTL_IEN]))
      else $error("irq does not follow done and enable");

   irq_drop_a: assert property ($fell(r.done) |-> !irq)
      else $error("irq stayed up after done cleared");

   go_gate_a: assert property (r.state == dmac_pkg::DMAC_IDLE && !r.ctrl[dmac_pkg::CTL_GO]
                               |=> r.state != dmac_pkg::DMAC_READ)
      else $error("transfer started with go low");

   status_clear_a: assert property (apb_wr && paddr == dmac_pkg::ADDR_STATUS && !end_now &&
                                    !(apb_wr && paddr == dmac_pkg::ADDR_CONTROL)
                                    |=> !r.done && !irq)
      else $error("status write did not clear done");

   raddr_fix_a: assert property (r.state == dmac_pkg::DMAC_READ && rd_ack &&
                                 r.ctrl[dmac_pkg::CTL_RFIX] && !apb_wr
                                 |=> $stable(r.raddr))
      else $error("fixed read address moved");

   raddr_step_a: assert property (r.state == dmac_pkg::DMAC_READ && rd_ack &&
                                  !r.ctrl[dmac_pkg::CTL_RFIX] && !apb_wr
                                  |=> r.raddr == $past(r.raddr) + $past(step))
      else $error("read address did not advance by the width");

   waddr_fix_a: assert property (wr_req && wr_ack && r.ctrl[dmac_pkg::CTL_WFIX] && !apb_wr
                                 |=> $stable(r.waddr))
      else $error("fixed write address moved");

   len_floor_a: assert property (wr_req && wr_ack && !apb_wr && r.len <= step
                                 |=> r.len == 32'h0000_0000 && r.lenf)
      else $error("length went below zero or flag missing");

   count_end_a: assert property (wr_req && wr_ack && !apb_wr && r.len <= step &&
                                 r.ctrl[dmac_pkg::CTL_COUNT_END_ENABLE]
                                 |=> r.done ##1 r.state == dmac_pkg::DMAC_IDLE)
      else $error("zero length did not end the transaction");

   // the write beat may wait on the slave, so allow a bounded gap
   read_end_a: assert property (rd_req && rd_ack && rd_eop && r.ctrl[dmac_pkg::CTL_READ_PACKET_END_ENABLE] &&
                                !apb_wr ##[1:16] wr_req && wr_ack &&
                                !(r.ctrl[dmac_pkg::CTL_WEEN] && wr_eop) &&
                                !apb_wr |=> r.done && r.read_packet_end_flag)
      else $error("read packet end did not end the transaction");

   busy_bit_a: assert property (apb_setup_rd && paddr == dmac_pkg::ADDR_STATUS
                                |=> r.prdata[dmac_pkg::STS_BUSY] ==
                                    ($past(r.state) != dmac_pkg::DMAC_IDLE))
      else $error("busy bit wrong");

   soft_reset_a: assert property (apb_wr && paddr == dmac_pkg::ADDR_CONTROL && r.armed &&
                                  pwdata[dmac_pkg::CTL_SRST]
                                  |=> r.ctrl == dmac_pkg::CTL_RESET && !r.armed &&
                                      r.state == dmac_pkg::DMAC_IDLE && !r.done)
      else $error("second soft reset write did not reset");

   // ----------------------------------------
   // further checks
   // ----------------------------------------
   width_out_a: assert property (width_sel == {r.ctrl[dmac_pkg::CTL_QWORD],
                                  r.ctrl[dmac_pkg::CTL_DWORD], r.ctrl[dmac_pkg::CTL_WORD],
                                  r.ctrl[dmac_pkg::CTL_HALF], r.ctrl[dmac_pkg::CTL_BYTE]})
      else $error("width select output differs from control");

   go_start_a: assert property (r.state == dmac_pkg::DMAC_IDLE &&
                                r.ctrl[dmac_pkg::CTL_GO] && r.len != 32'h0000_0000 &&
                                !r.done && !apb_wr |=> rd_req)
      else $error("transfer did not start with go set");

   one_beat_a: assert property (!(rd_req && wr_req))
      else $error("read and write requested together");

   rd_hold_a: assert property (rd_req && !rd_ack && !apb_wr
                               |=> rd_req && $stable(rd_addr))
      else $error("read request dropped before ack");

   wr_hold_a: assert property (wr_req && !wr_ack && !apb_wr
                               |=> wr_req && $stable(wr_addr) && $stable(wr_data))
      else $error("write request dropped before ack");

   beat_data_a: assert property (rd_req && rd_ack |=> wr_data == $past(rd_data))
      else $error("read data not passed to the write side");

   irq_off_a: assert property (!r.ctrl[dmac_pkg::CTL_IEN] |-> !irq)
      else $error("irq high with enable clear");

   irq_en_drop_a: assert property ($fell(r.ctrl[dmac_pkg::CTL_IEN]) |-> !irq)
      else $error("irq stayed up after enable cleared");

   write_end_a: assert property (wr_req && wr_ack && wr_eop &&
                                 r.ctrl[dmac_pkg::CTL_WEEN] && !apb_wr
                                 |=> r.done && r.write_packet_end_flag && r.state == dmac_pkg::DMAC_IDLE)
      else $error("write packet end did not end the transaction");

   no_count_end_a: assert property (wr_req && wr_ack && !r.ctrl[dmac_pkg::CTL_COUNT_END_ENABLE] &&
                                    !r.eop_pend && !(r.ctrl[dmac_pkg::CTL_WEEN] && wr_eop) &&
                                    !apb_wr |=> !r.done)
      else $error("zero length ended a transaction with count end off");

   waddr_step_a: assert property (wr_req && wr_ack && !r.ctrl[dmac_pkg::CTL_WFIX] &&
                                  !apb_wr |=> r.waddr == $past(r.waddr) + $past(step))
      else $error("write address did not advance by the width");

   len_step_a: assert property (wr_req && wr_ack && !apb_wr && r.len > step
                                |=> r.len == $past(r.len) - $past(step))
      else $error("length did not drop by the width");

   len_hold_a: assert property (!(wr_req && wr_ack) && !apb_wr |=> $stable(r.len))
      else $error("length moved without a write beat");

   done_hold_a: assert property (r.done && !apb_wr |=> r.done)
      else $error("done cleared without a status write");

   read_packet_end_flag_hold_a: assert property (r.read_packet_end_flag && !apb_wr |=> r.read_packet_end_flag)
      else $error("read end flag lost");

   write_packet_end_flag_hold_a: assert property (r.write_packet_end_flag && !apb_wr |=> r.write_packet_end_flag)
      else $error("write end flag lost");

   lenf_hold_a: assert property (r.lenf && !apb_wr |=> r.lenf)
      else $error("length flag lost");

   ctrl_read_a: assert property (apb_setup_rd && paddr == dmac_pkg::ADDR_CONTROL
                                 |=> r.prdata[11:0] == $past(r.ctrl))
      else $error("control read back wrong");

   ctrl_stable_a: assert property (!apb_wr |=> $stable(r.ctrl))
      else $error("control changed without a write");

   done_read_a: assert property (apb_setup_rd && paddr == dmac_pkg::ADDR_STATUS
                                 |=> r.prdata[dmac_pkg::STS_DONE] == $past(r.done))
      else $error("done bit read back wrong");

   soft_arm_a: assert property (apb_wr && paddr == dmac_pkg::ADDR_CONTROL &&
                                !pwdata[dmac_pkg::CTL_SRST] |=> !r.armed)
      else $error("soft reset stayed armed");

endmodule

// ### verif/dmac_slave_model.sv
// slave memories on the read and write sides of the dma block
// assumes one beat at a time, request held until its ack edge
`timescale 1ns/1ns

module dmac_slave_model (
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire logic rd_req,
   input wire logic [31:0] rd_addr,
   output logic rd_ack,
   output logic [127:0] rd_data,
   output logic rd_eop,
   input wire logic wr_req,
   input wire logic [31:0] wr_addr,
   input wire logic [127:0] wr_data,
   output logic wr_ack,
   output logic wr_eop,
   input wire logic [31:0] eop_rd_at,
   input wire logic [31:0] eop_wr_at,
   input wire logic [3:0] delay,
   output logic [31:0] last_addr,
   output logic [127:0] last_data,
   output logic [7:0] n_writes
);
   logic [3:0] cnt;
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         {rd_ack, rd_eop, wr_ack, wr_eop, cnt, n_writes, last_addr} <= '0;
         rd_data <= '0;
         last_data <= '0;
      end else begin
         {rd_ack, rd_eop, wr_ack, wr_eop} <= 4'h0;
         // data not valid outside the ack cycle, so keep it moving
         rd_data <= ~rd_data;
         if ((rd_req && !rd_ack) || (wr_req && !wr_ack)) begin
            cnt <= cnt + 4'h1;
            if (cnt >= delay) begin
               cnt <= 4'h0;
               if (rd_req) begin
                  rd_ack <= 1'b1;
                  rd_data <= {4{rd_addr ^ 32'h5A00_0000}};
                  rd_eop <= rd_addr == eop_rd_at;
               end else begin
                  wr_ack <= 1'b1;
                  wr_eop <= wr_addr == eop_wr_at;
                  last_addr <= wr_addr;
                  last_data <= wr_data;
                  n_writes <= n_writes + 8'h1;
               end
            end
         end
      end
   end
endmodule

// ### verif/dma_control_and_irq_tb.sv
// self-checking bench: apb master tasks and transfer scenarios
// assumes the slave model answers every beat after delay cycles
`timescale 1ns/1ns

module dma_control_and_irq_tb;
   localparam logic [31:0] BYTE = 32'h1, HALF = 32'h2, WORD = 32'h4, GO = 32'h8, IEN = 32'h10;
   localparam logic [31:0] RDEND = 32'h20, WREND = 32'h40, CNTEND = 32'h80, RFIX = 32'h100;
   localparam logic [31:0] WFIX = 32'h200, SRST = 32'h1000, NEVER = 32'hFFFF_FFFF;
   logic ref_clk = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, eop_rd_at = NEVER, eop_wr_at = NEVER;
   logic [31:0] prdata, q, rd_addr, wr_addr, last_addr;
   logic pready, pslverr, perr, rd_req, rd_ack, rd_eop, wr_req, wr_ack, wr_eop, irq;
   logic [127:0] rd_data, wr_data, last_data;
   logic [4:0] width_sel;
   logic [3:0] delay = 4'h6;
   logic [7:0] n_writes, n0;
   int error_cnt = 0;
   int num_checks = 0;
   int wb [5] = '{0, 1, 2, 10, 11};
   always #50 ref_clk = ~ref_clk;

   dmac_top i_dmac_top (.ref_clk(ref_clk), .rst_b(rst_b), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .rd_req(rd_req), .rd_addr(rd_addr), .rd_ack(rd_ack),
      .rd_data(rd_data), .rd_eop(rd_eop), .wr_req(wr_req), .wr_addr(wr_addr),
      .wr_data(wr_data), .wr_ack(wr_ack), .wr_eop(wr_eop), .width_sel(width_sel), .irq(irq));
   dmac_slave_model i_dmac_slave_model (.ref_clk(ref_clk), .rst_b(rst_b), .rd_req(rd_req),
      .rd_addr(rd_addr), .rd_ack(rd_ack), .rd_data(rd_data), .rd_eop(rd_eop),
      .wr_req(wr_req), .wr_addr(wr_addr), .wr_data(wr_data), .wr_ack(wr_ack),
      .wr_eop(wr_eop), .eop_rd_at(eop_rd_at), .eop_wr_at(eop_wr_at), .delay(delay),
      .last_addr(last_addr), .last_data(last_data), .n_writes(n_writes));

   // ----------------------------------------
   // bus tasks
   // ----------------------------------------
   task automatic final_report();
      $display("checks %0d errors %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // entered just after a rising edge; leaves one idle cycle behind
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      do begin
         @(posedge ref_clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) begin
         error_cnt++;
         final_report();
      end
      q = prdata;
      perr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge ref_clk);
   endtask

   task automatic rdc(input string name, input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      check(name, q, exp);
   endtask

   task automatic xfer(input logic [31:0] ra, wa, len, ctl, input logic [7:0] nw,
                       input logic [31:0] st);
      int n;
      n = 0;
      // stop the engine first: old go plus a fresh length would start it early
      apb(1'b1, dmac_pkg::ADDR_CONTROL, 32'h0);
      apb(1'b1, dmac_pkg::ADDR_STATUS, 32'h0);
      n0 = n_writes;
      apb(1'b1, dmac_pkg::ADDR_RADDR, ra);
      apb(1'b1, dmac_pkg::ADDR_WADDR, wa);
      apb(1'b1, dmac_pkg::ADDR_LENGTH, len);
      apb(1'b1, dmac_pkg::ADDR_CONTROL, ctl);
      if (ctl[3] && delay != 4'h0) rdc("busy", dmac_pkg::ADDR_STATUS, 32'h2);
      do begin
         apb(1'b0, dmac_pkg::ADDR_STATUS, 32'h0);
         n++;
      end while (q[1] !== 1'b0 && n < 40);
      if (q[1] !== 1'b0) begin
         error_cnt++;
         final_report();
      end
      check("beats", {24'h0, n_writes - n0}, {24'h0, nw});
      check("status", q, st);
   endtask

   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   initial begin
      repeat (10) @(posedge ref_clk);
      rst_b <= 1'b1;
      @(posedge ref_clk);
      rdc("control", dmac_pkg::ADDR_CONTROL, 32'h0);
      rdc("status", dmac_pkg::ADDR_STATUS, 32'h0);
      apb(1'b0, 12'h010, 32'h0);
      check("unmapped err", {31'h0, perr}, 32'h1);
      check("unmapped data", q, 32'h0);
      foreach (wb[i]) begin
         apb(1'b1, dmac_pkg::ADDR_CONTROL, 32'h1 << wb[i]);
         rdc("control", dmac_pkg::ADDR_CONTROL, 32'h1 << wb[i]);
         check("width_sel", {27'h0, width_sel}, 32'h1 << i);
      end
      xfer(32'h100, 32'h200, 32'h8, WORD | CNTEND, 8'h0, 32'h0);
      xfer(32'h100, 32'h200, 32'h8, WORD | CNTEND | GO | IEN, 8'h2, 32'h11);
      check("irq", {31'h0, irq}, 32'h1);
      check("waddr out", last_addr, 32'h204);
      check("data", last_data[31:0], 32'h5A00_0104);
      rdc("raddr", dmac_pkg::ADDR_RADDR, 32'h108);
      rdc("length", dmac_pkg::ADDR_LENGTH, 32'h0);
      rdc("status", dmac_pkg::ADDR_STATUS, 32'h11);
      apb(1'b1, dmac_pkg::ADDR_STATUS, 32'h0);
      check("irq", {31'h0, irq}, 32'h0);
      rdc("status", dmac_pkg::ADDR_STATUS, 32'h0);
      delay <= 4'h0;
      xfer(32'h500, 32'h400, 32'h6, HALF | CNTEND | RFIX | WFIX | GO, 8'h3, 32'h11);
      check("irq off", {31'h0, irq}, 32'h0);
      check("waddr out", last_addr, 32'h400);
      check("data", {16'h0, last_data[15:0]}, 32'h0500);
      rdc("raddr", dmac_pkg::ADDR_RADDR, 32'h500);
      rdc("waddr", dmac_pkg::ADDR_WADDR, 32'h400);
      eop_rd_at <= 32'h604;
      xfer(32'h600, 32'h700, 32'h10, WORD | CNTEND | RDEND | GO, 8'h2, 32'h05);
      rdc("length", dmac_pkg::ADDR_LENGTH, 32'h8);
      xfer(32'h600, 32'h700, 32'h10, WORD | CNTEND | GO, 8'h4, 32'h11);
      eop_rd_at <= NEVER;
      eop_wr_at <= 32'h808;
      xfer(32'h800, 32'h800, 32'h40, WORD | WREND | GO, 8'h3, 32'h09);
      eop_wr_at <= NEVER;
      xfer(32'h900, 32'hA00, 32'h8, WORD | GO, 8'h2, 32'h10);
      apb(1'b1, dmac_pkg::ADDR_CONTROL, SRST | BYTE);
      rdc("armed", dmac_pkg::ADDR_CONTROL, SRST | BYTE);
      apb(1'b1, dmac_pkg::ADDR_CONTROL, SRST);
      rdc("control", dmac_pkg::ADDR_CONTROL, 32'h0);
      rdc("raddr", dmac_pkg::ADDR_RADDR, 32'h0);
      rdc("status", dmac_pkg::ADDR_STATUS, 32'h0);
      check("width_sel", {27'h0, width_sel}, 32'h0);
      final_report();
   end
endmodule
